// >>> hw/bdl_pkg.sv
// Package of constants and types for the board diagnostic lamp controller.
package bdl_pkg;

    // ****************************************************************
    // Clock and blink timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 125000000;
    // Slow blink rate in hertz, used for degraded and non-fatal patterns.
    localparam int unsigned SLOW_BLINK_HZ = 1;
    // Fast blink rate in hertz, used while the controller sits in its loader.
    localparam int unsigned FAST_BLINK_HZ = 3;
    // Timed identify interval in seconds.
    localparam int unsigned IDENT_TIMED_S = 15;
    // Half periods in clock cycles, rounded down.
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
    // Number of slow half periods that fill the timed identify interval.
    localparam int unsigned IDENT_HALVES = IDENT_TIMED_S * 2 * SLOW_BLINK_HZ;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_HEALTH = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_PROGRESS = 12'h00c;

    // Control register bits.
    localparam int unsigned CTRL_IDENT_TIMED = 0;
    localparam int unsigned CTRL_IDENT_ENDLESS = 1;
    localparam int unsigned CTRL_IDENT_STOP = 2;
    localparam int unsigned CTRL_MC_LOADER = 3;
    localparam int unsigned CTRL_MC_BOOTING = 4;
    localparam int unsigned CTRL_MC_READY = 5;

    // Health register bits, one per severity class.
    localparam int unsigned HEALTH_DEGRADED = 0;
    localparam int unsigned HEALTH_NONFATAL = 1;
    localparam int unsigned HEALTH_FATAL = 2;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        BDL_IDENT_OFF,
        BDL_IDENT_STEADY,
        BDL_IDENT_BLINK_TIMED,
        BDL_IDENT_BLINK_ENDLESS
    } bdl_ident_t;

    typedef enum logic [2:0] {
        BDL_STAT_OFF,
        BDL_STAT_GREEN,
        BDL_STAT_GREEN_BLINK,
        BDL_STAT_AMBER_BLINK,
        BDL_STAT_AMBER
    } bdl_stat_t;

endpackage : bdl_pkg

// >>> hw/bdl_led_ctrl.sv
// Board diagnostic lamp controller with an APB register slave.
//
// Function
// - Standby lamp lit while mains present and standby rail delivered.
// - Two fan fault lamps, each lit only while its own fan faults.
// - Memory slot lamp lit only when populated and error flagged.
// - Identify button press toggles blue lamp steady on and off.
// - Identify request blinks lamp, timed fifteen seconds or until stopped.
// - Status steady green: mains present, controller booted, no errors.
// - Status blinks green at one hertz on any degraded condition.
// - Status blinks amber at one hertz on a non-fatal alarm.
// - Status steady amber on any fatal condition.
// - Loader: identify blinks 3 Hz; main boot: identify steady, status degraded.
// - On host soft-off the status lamp keeps its earlier state.
// - If status was steady green at power-down it turns off.
// - Firmware writes a progress code; it is held until the next.
// - Eight progress lamps, lamp 7 the top bit, lamp 0 bottom.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module bdl_led_ctrl #(
    parameter int unsigned NUM_SLOTS = 8,
    parameter int unsigned SLOW_HALF = bdl_pkg::SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = bdl_pkg::FAST_HALF_CYC,
    parameter int unsigned IDENT_HALVES = bdl_pkg::IDENT_HALVES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Board inputs, asynchronous to clk
    input wire logic mains_present,
    input wire logic standby_rail_ok,
    input wire logic host_powered,
    input wire logic ident_button,
    input wire logic [1:0] fan_fault,
    input wire logic [NUM_SLOTS-1:0] slot_populated,
    input wire logic [NUM_SLOTS-1:0] slot_error,
    // Lamp drives, high means lit
    output logic standby_lamp,
    output logic [1:0] fan_lamp,
    output logic [NUM_SLOTS-1:0] slot_lamp,
    output logic ident_lamp,
    output logic status_green,
    output logic status_amber,
    output logic [7:0] progress_lamp
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    // Elaboration stops here rather than building counters that can never wrap.
    if (NUM_SLOTS < 1 || NUM_SLOTS > 32 || SLOW_HALF < 1 || FAST_HALF < 1 || IDENT_HALVES < 1) begin : g_bad_param
        $error("bdl_led_ctrl: unsupported parameter value");
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int unsigned SYNC_W = 6 + 2 * NUM_SLOTS;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {slot_error, slot_populated, fan_fault, ident_button, host_powered,
                       standby_rail_ok, mains_present};
            sync_b <= sync_a;
        end
    end
    logic mains_ok;
    logic host_on;
    logic button;
    logic [1:0] fan_s;
    logic [NUM_SLOTS-1:0] pop_s;
    logic [NUM_SLOTS-1:0] err_s;
    // Each supply pin is synchronised on its own; gating them before the flops would be unsafe.
    assign mains_ok = sync_b[0] & sync_b[1];
    assign host_on = sync_b[2];
    assign button = sync_b[3];
    assign fan_s = sync_b[5:4];
    assign pop_s = sync_b[5+NUM_SLOTS:6];
    assign err_s = sync_b[5+2*NUM_SLOTS:6+NUM_SLOTS];

    // ****************************************************************
    // APB register slave
    // ****************************************************************
    logic [5:0] ctrl;
    logic [2:0] health;
    logic [7:0] progress;
    logic wr_en;
    logic ident_cmd_timed;
    logic ident_cmd_endless;
    logic ident_cmd_stop;
    logic known_addr;
    bdl_pkg::bdl_ident_t ident_state;
    bdl_pkg::bdl_stat_t stat_shown;

    // Single-cycle access phase: the slave is always ready.
    assign pready = 1'b1;
    assign known_addr = paddr == bdl_pkg::ADDR_CTRL || paddr == bdl_pkg::ADDR_HEALTH ||
                        paddr == bdl_pkg::ADDR_STATUS || paddr == bdl_pkg::ADDR_PROGRESS;
    assign pslverr = psel & penable & ~known_addr;
    assign wr_en = psel & penable & pwrite & pstrb[0];
    // Identify commands are self-clearing strobes rather than stored bits.
    assign ident_cmd_timed = wr_en && paddr == bdl_pkg::ADDR_CTRL && pwdata[bdl_pkg::CTRL_IDENT_TIMED];
    assign ident_cmd_endless = wr_en && paddr == bdl_pkg::ADDR_CTRL && pwdata[bdl_pkg::CTRL_IDENT_ENDLESS];
    assign ident_cmd_stop = wr_en && paddr == bdl_pkg::ADDR_CTRL && pwdata[bdl_pkg::CTRL_IDENT_STOP];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
            health <= '0;
        end else if (wr_en && paddr == bdl_pkg::ADDR_CTRL) begin
            ctrl <= {pwdata[bdl_pkg::CTRL_MC_READY:bdl_pkg::CTRL_MC_LOADER], 3'h0};
        end else if (wr_en && paddr == bdl_pkg::ADDR_HEALTH) begin
            health <= pwdata[2:0];
        end
    end

    // The code is latched on each write with byte lane 0 enabled and held until the next one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            progress <= '0;
        end else if (wr_en && paddr == bdl_pkg::ADDR_PROGRESS) begin
            progress <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= bdl_pkg::RESET_WORD;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                bdl_pkg::ADDR_CTRL: prdata <= {26'h0, ctrl};
                bdl_pkg::ADDR_HEALTH: prdata <= {29'h0, health};
                bdl_pkg::ADDR_STATUS: prdata <= {24'h0, host_on, mains_ok, ident_state, 1'b0, stat_shown};
                bdl_pkg::ADDR_PROGRESS: prdata <= {24'h0, progress};
                default: prdata <= bdl_pkg::RESET_WORD;
            endcase
        end
    end

    // ****************************************************************
    // Blink generators
    // ****************************************************************
    logic [31:0] slow_cnt;
    logic [31:0] fast_cnt;
    logic slow_phase;
    logic fast_phase;
    logic slow_half_end;
    assign slow_half_end = slow_cnt == 32'(SLOW_HALF - 1);

    // Even on and off halves, counted from the standby clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slow_cnt <= '0;
            slow_phase <= 1'b0;
        end else if (slow_half_end) begin
            slow_cnt <= '0;
            slow_phase <= ~slow_phase;
        end else begin
            slow_cnt <= slow_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fast_cnt <= '0;
            fast_phase <= 1'b0;
        end else if (fast_cnt == 32'(FAST_HALF - 1)) begin
            fast_cnt <= '0;
            fast_phase <= ~fast_phase;
        end else begin
            fast_cnt <= fast_cnt + 32'h1;
        end
    end

    // ****************************************************************
    // Identify lamp
    // ****************************************************************
    logic button_d;
    logic button_press;
    logic [31:0] ident_halves;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            button_d <= 1'b0;
        end else begin
            button_d <= button;
        end
    end
    assign button_press = button & ~button_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ident_state <= bdl_pkg::BDL_IDENT_OFF;
            ident_halves <= '0;
        end else if (ident_cmd_stop) begin
            ident_state <= bdl_pkg::BDL_IDENT_OFF;
        end else if (ident_cmd_endless) begin
            ident_state <= bdl_pkg::BDL_IDENT_BLINK_ENDLESS;
        end else if (ident_cmd_timed) begin
            ident_state <= bdl_pkg::BDL_IDENT_BLINK_TIMED;
            ident_halves <= '0;
        end else begin
            case (ident_state)
                bdl_pkg::BDL_IDENT_OFF: begin
                    if (button_press) begin
                        ident_state <= bdl_pkg::BDL_IDENT_STEADY;
                    end
                end
                bdl_pkg::BDL_IDENT_STEADY: begin
                    if (button_press) begin
                        ident_state <= bdl_pkg::BDL_IDENT_OFF;
                    end
                end
                bdl_pkg::BDL_IDENT_BLINK_TIMED: begin
                    if (button_press) begin
                        ident_state <= bdl_pkg::BDL_IDENT_STEADY;
                    end else if (slow_half_end) begin
                        if (ident_halves == 32'(IDENT_HALVES - 1)) begin
                            ident_state <= bdl_pkg::BDL_IDENT_OFF;
                        end
                        ident_halves <= ident_halves + 32'h1;
                    end
                end
                bdl_pkg::BDL_IDENT_BLINK_ENDLESS: begin
                    if (button_press) begin
                        ident_state <= bdl_pkg::BDL_IDENT_STEADY;
                    end
                end
                default: ident_state <= bdl_pkg::BDL_IDENT_OFF;
            endcase
        end
    end

    // The controller's own boot phases override the identify state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ident_lamp <= 1'b0;
        end else if (ctrl[bdl_pkg::CTRL_MC_LOADER]) begin
            ident_lamp <= fast_phase;
        end else if (ctrl[bdl_pkg::CTRL_MC_BOOTING]) begin
            ident_lamp <= 1'b1;
        end else begin
            case (ident_state)
                bdl_pkg::BDL_IDENT_STEADY: ident_lamp <= 1'b1;
                bdl_pkg::BDL_IDENT_BLINK_TIMED: ident_lamp <= slow_phase;
                bdl_pkg::BDL_IDENT_BLINK_ENDLESS: ident_lamp <= slow_phase;
                default: ident_lamp <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Status lamp
    // ****************************************************************
    bdl_pkg::bdl_stat_t next_stat;
    logic degraded;
    assign degraded = health[bdl_pkg::HEALTH_DEGRADED] | ctrl[bdl_pkg::CTRL_MC_LOADER] |
                      ctrl[bdl_pkg::CTRL_MC_BOOTING] | ~ctrl[bdl_pkg::CTRL_MC_READY];

    always_comb begin
        if (health[bdl_pkg::HEALTH_FATAL]) begin
            next_stat = bdl_pkg::BDL_STAT_AMBER;
        end else if (health[bdl_pkg::HEALTH_NONFATAL]) begin
            next_stat = bdl_pkg::BDL_STAT_AMBER_BLINK;
        end else if (degraded) begin
            next_stat = bdl_pkg::BDL_STAT_GREEN_BLINK;
        end else begin
            next_stat = bdl_pkg::BDL_STAT_GREEN;
        end
    end

    // While the host is off the shown state freezes; a healthy green goes dark.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_shown <= bdl_pkg::BDL_STAT_OFF;
        end else if (!mains_ok) begin
            stat_shown <= bdl_pkg::BDL_STAT_OFF;
        end else if (host_on) begin
            stat_shown <= next_stat;
        end else if (stat_shown == bdl_pkg::BDL_STAT_GREEN) begin
            stat_shown <= bdl_pkg::BDL_STAT_OFF;
        end else begin
            stat_shown <= stat_shown;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_green <= 1'b0;
            status_amber <= 1'b0;
        end else begin
            case (stat_shown)
                bdl_pkg::BDL_STAT_GREEN: begin
                    status_green <= 1'b1;
                    status_amber <= 1'b0;
                end
                bdl_pkg::BDL_STAT_GREEN_BLINK: begin
                    status_green <= slow_phase;
                    status_amber <= 1'b0;
                end
                bdl_pkg::BDL_STAT_AMBER_BLINK: begin
                    status_green <= 1'b0;
                    status_amber <= slow_phase;
                end
                bdl_pkg::BDL_STAT_AMBER: begin
                    status_green <= 1'b0;
                    status_amber <= 1'b1;
                end
                default: begin
                    status_green <= 1'b0;
                    status_amber <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Fault, presence and progress lamps
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            standby_lamp <= 1'b0;
            fan_lamp <= '0;
            progress_lamp <= '0;
        end else begin
            standby_lamp <= mains_ok;
            fan_lamp <= fan_s;
            progress_lamp <= progress;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    slot_lamp[gi] <= 1'b0;
                end else begin
                    slot_lamp[gi] <= pop_s[gi] & err_s[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence fatal_seen_s;
        mains_ok && host_on && health[bdl_pkg::HEALTH_FATAL];
    endsequence

    fatal_amber_a: assert property (@(posedge clk) disable iff (rst)
        fatal_seen_s |=> ##1 (status_amber && !status_green))
        else $error("fatal condition did not give steady amber");

    no_mains_dark_a: assert property (@(posedge clk) disable iff (rst)
        !mains_ok |=> ##1 (!status_green && !status_amber))
        else $error("status lamp lit without mains");

    standby_lamp_a: assert property (@(posedge clk) disable iff (rst)
        standby_lamp == $past(mains_ok))
        else $error("standby lamp does not follow mains");

    green_off_a: assert property (@(posedge clk) disable iff (rst)
        (mains_ok && !host_on && stat_shown == bdl_pkg::BDL_STAT_GREEN) |=> stat_shown == bdl_pkg::BDL_STAT_OFF)
        else $error("green held at power-down");

    hold_state_a: assert property (@(posedge clk) disable iff (rst)
        (mains_ok && !host_on && stat_shown != bdl_pkg::BDL_STAT_GREEN) |=> $stable(stat_shown))
        else $error("status changed while host off");

    button_toggle_a: assert property (@(posedge clk) disable iff (rst)
        (button_press && ident_state == bdl_pkg::BDL_IDENT_OFF && !wr_en) |=>
            ident_state == bdl_pkg::BDL_IDENT_STEADY)
        else $error("button did not light identify");

    progress_hold_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && paddr == bdl_pkg::ADDR_PROGRESS) |=> ##1 progress_lamp == $past(pwdata[7:0], 2))
        else $error("progress code not shown");

    slot_lamp_a: assert property (@(posedge clk) disable iff (rst)
        (slot_lamp != '0) |-> ($past(pop_s) & $past(err_s)) == slot_lamp)
        else $error("slot lamp lit without populated error");

endmodule : bdl_led_ctrl

// >>> bench/bdl_mc_model.sv
// Management controller model: an APB master that runs one request at a time.
`timescale 1ns/100ps

module bdl_mc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request side
    input wire logic go,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] strb,
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata
);
    // The request stands until pready is seen with penable; afterwards the
    // address and data lines are scrambled so a stale value cannot pass.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 12'h000;
            pwdata <= 32'h0000_0000;
            pstrb <= 4'h0;
            rdata <= 32'h0000_0000;
            err <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!psel && go) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
                pstrb <= strb;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                rdata <= prdata;
                err <= pslverr;
                done <= 1'b1;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end
        end
    end
endmodule : bdl_mc_model

// >>> bench/board_diagnostic_led_controller_bench.sv
// Self-checking bench for the board diagnostic lamp controller.
`timescale 1ns/100ps

module board_diagnostic_led_controller_bench;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, wr = 1'b0, done, err;
    logic [11:0] addr = 12'h000, paddr;
    logic [31:0] wdata = 32'h0000_0000, rdata, pwdata, prdata;
    logic psel, penable, pwrite, pready, pslverr;
    logic [3:0] pstrb, strb = 4'hf;
    logic mains = 1'b1, rail = 1'b1, host = 1'b1, button = 1'b0;
    logic [1:0] fan_fault = 2'h0, fan_lamp;
    logic [7:0] slot_pop = 8'h00, slot_err = 8'h00, slot_lamp, progress_lamp;
    logic standby_lamp, ident_lamp, status_green, status_amber;
    int n_mismatch = 0, n_checks = 0, cycles = 0;

    bdl_mc_model u_mc (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata), .done(done),
        .rdata(rdata), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .strb(strb), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata));
    bdl_led_ctrl #(.NUM_SLOTS(8), .SLOW_HALF(4), .FAST_HALF(2), .IDENT_HALVES(4)) u_dut (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mains_present(mains), .standby_rail_ok(rail),
        .host_powered(host), .ident_button(button), .fan_fault(fan_fault), .slot_populated(slot_pop),
        .slot_error(slot_err), .standby_lamp(standby_lamp), .fan_lamp(fan_lamp), .slot_lamp(slot_lamp),
        .ident_lamp(ident_lamp), .status_green(status_green), .status_amber(status_amber),
        .progress_lamp(progress_lamp));

    initial begin
        forever #4 clk = ~clk;
    end

    // A run that overruns 20000 cycles ends here instead of spinning forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n < 50}, 32'h1);
    endtask : bus

    task automatic pause(input int c);
        repeat (c) @(posedge clk);
    endtask : pause

    task automatic stat(input logic [31:0] msk, input logic [31:0] exp);
        pause(8);
        bus(1'b0, bdl_pkg::ADDR_STATUS, 32'h0);
        chk(rdata & msk, exp);
    endtask : stat

    // Counts lit samples of one lamp: 0 ident, 1 green, 2 amber.
    task automatic lit(input int b, input int c, input int exp);
        int on;
        logic [2:0] v;
        on = 0;
        repeat (c) begin
            @(posedge clk);
            #1 v = {status_amber, status_green, ident_lamp};
            on += v[b];
        end
        chk(on, exp);
    endtask : lit

    task automatic t_pins();
        logic [1:0] f;
        for (int i = 0; i < 4; i++) begin
            f = 2'(i);
            mains <= f[1];
            rail <= f[0];
            fan_fault <= f;
            slot_pop <= {4{f}};
            slot_err <= 8'h5a;
            pause(6);
            chk(standby_lamp, f[1] & f[0]);
            chk(fan_lamp, f);
            chk(slot_lamp, {4{f}} & 8'h5a);
        end
        $display("pins test done");
    endtask : t_pins

    task automatic t_ident();
        repeat (2) begin
            button <= ~button;
            pause(6);
        end
        stat(32'h30, 32'h10);
        chk(ident_lamp, 1'b1);
        repeat (2) begin
            button <= ~button;
            pause(6);
        end
        stat(32'h30, 32'h00);
        bus(1'b1, bdl_pkg::ADDR_CTRL, 32'h21);
        stat(32'h30, 32'h20);
        pause(30);
        stat(32'h30, 32'h00);
        chk(ident_lamp, 1'b0);
        bus(1'b1, bdl_pkg::ADDR_CTRL, 32'h22);
        pause(40);
        lit(0, 16, 8);
        bus(1'b1, bdl_pkg::ADDR_CTRL, 32'h24);
        stat(32'h30, 32'h00);
        $display("identify test done");
    endtask : t_ident

    task automatic t_status();
        logic [31:0] e;
        for (int h = 0; h < 8; h++) begin
            bus(1'b1, bdl_pkg::ADDR_HEALTH, h);
            e = h[2] ? bdl_pkg::BDL_STAT_AMBER : h[1] ? bdl_pkg::BDL_STAT_AMBER_BLINK :
                h[0] ? bdl_pkg::BDL_STAT_GREEN_BLINK : bdl_pkg::BDL_STAT_GREEN;
            stat(32'h7, e);
            if (h == 0) chk({status_green, status_amber}, 2'b10);
            if (h == 1) lit(1, 16, 8);
            if (h == 2) lit(2, 16, 8);
            if (h == 4) chk({status_green, status_amber}, 2'b01);
        end
        bus(1'b1, bdl_pkg::ADDR_HEALTH, 32'h1);
        host <= 1'b0;
        pause(8);
        bus(1'b1, bdl_pkg::ADDR_HEALTH, 32'h4);
        stat(32'h7, bdl_pkg::BDL_STAT_GREEN_BLINK);
        host <= 1'b1;
        bus(1'b1, bdl_pkg::ADDR_HEALTH, 32'h0);
        stat(32'h7, bdl_pkg::BDL_STAT_GREEN);
        host <= 1'b0;
        stat(32'h7, bdl_pkg::BDL_STAT_OFF);
        chk({status_green, status_amber}, 2'b00);
        host <= 1'b1;
        mains <= 1'b0;
        stat(32'h7, bdl_pkg::BDL_STAT_OFF);
        mains <= 1'b1;
        bus(1'b1, bdl_pkg::ADDR_CTRL, 32'h28);
        pause(10);
        lit(0, 12, 6);
        stat(32'h7, bdl_pkg::BDL_STAT_GREEN_BLINK);
        bus(1'b1, bdl_pkg::ADDR_CTRL, 32'h30);
        pause(8);
        lit(0, 12, 12);
        stat(32'h7, bdl_pkg::BDL_STAT_GREEN_BLINK);
        $display("status test done");
    endtask : t_status

    task automatic t_progress();
        bus(1'b1, bdl_pkg::ADDR_PROGRESS, 32'ha5);
        bus(1'b1, bdl_pkg::ADDR_PROGRESS, 32'h81);
        pause(3);
        chk(progress_lamp, 8'h81);
        // A write without its low byte lane must leave the held code alone.
        strb <= 4'he;
        bus(1'b1, bdl_pkg::ADDR_PROGRESS, 32'h33);
        strb <= 4'hf;
        bus(1'b0, bdl_pkg::ADDR_PROGRESS, 32'h0);
        chk(rdata, 32'h81);
        bus(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(rdata, 32'h0);
        $display("progress test done");
    endtask : t_progress

    initial begin
        pause(12);
        rst <= 1'b0;
        pause(1);
        bus(1'b0, bdl_pkg::ADDR_CTRL, 32'h0);
        chk(rdata, bdl_pkg::RESET_WORD);
        t_pins();
        bus(1'b1, bdl_pkg::ADDR_CTRL, 32'h20);
        t_ident();
        t_status();
        t_progress();
        final_report();
    end
endmodule : board_diagnostic_led_controller_bench
